// ===== tw_pkg.sv
// Shared constants, types and decoders for the two-wire flash programming registers.
// Assumes every module of the block imports this package whole.
package tw_pkg;
   // Link register addresses
   localparam logic [7:0] TW_ADDR_PART = 8'h00;
   localparam logic [7:0] TW_ADDR_REV  = 8'h01;
   localparam logic [7:0] TW_ADDR_CTL  = 8'h02;
   localparam logic [7:0] TW_ADDR_DAT  = 8'had;
   // Values after reset
   localparam logic [7:0] TW_SEL_RST   = 8'h00;
   localparam logic [7:0] TW_CTL_RST   = 8'h00;
   localparam logic [7:0] TW_DAT_RST   = 8'h00;
   // Enable codes, in the order they must arrive
   localparam logic [7:0] TW_EN_CODE1  = 8'h02;
   localparam logic [7:0] TW_EN_CODE2  = 8'h01;
   // Flash command codes
   localparam logic [7:0] TW_CMD_BLK_RD = 8'h06;
   localparam logic [7:0] TW_CMD_BLK_WR = 8'h07;
   localparam logic [7:0] TW_CMD_PG_ER  = 8'h08;
   localparam logic [7:0] TW_CMD_DEV_ER = 8'h03;
   // Link bit counts, counted from zero
   localparam logic [2:0] TW_INS_LAST  = 3'h1;
   localparam logic [2:0] TW_BYTE_LAST = 3'h7;

   typedef enum logic [1:0] {
      TW_I_DRD = 2'b00,
      TW_I_DWR = 2'b01,
      TW_I_ARD = 2'b10,
      TW_I_AWR = 2'b11
   } tw_instr_e;

   typedef enum logic [2:0] {
      TW_FC_NONE   = 3'b000,
      TW_FC_BLK_RD = 3'b001,
      TW_FC_BLK_WR = 3'b010,
      TW_FC_PG_ER  = 3'b011,
      TW_FC_DEV_ER = 3'b100
   } tw_fcmd_e;

   function automatic tw_fcmd_e tw_cmd_decode(input logic [7:0] code);
      if (code == TW_CMD_BLK_RD) return TW_FC_BLK_RD;
      else if (code == TW_CMD_BLK_WR) return TW_FC_BLK_WR;
      else if (code == TW_CMD_PG_ER) return TW_FC_PG_ER;
      else if (code == TW_CMD_DEV_ER) return TW_FC_DEV_ER;
      else return TW_FC_NONE;
   endfunction
endpackage

// ===== tw_xfer_if.sv
// Request and answer handshake between the link-clock engine and the core registers.
// Assumes request fields stay stable from a request toggle until its answer toggle.
`timescale 1ns/10ps
interface tw_xfer_if;
   import tw_pkg::*;
   logic       req_tog;
   tw_instr_e  instr;
   logic [7:0] wdata;
   logic       ack_tog;
   logic [7:0] rdata;
   logic       halted;
   modport link (output req_tog, instr, wdata, input ack_tog, rdata, halted);
   modport core (input req_tog, instr, wdata, output ack_tog, rdata, halted);
endinterface

// ===== tw_sync.sv
// Three-stage synchroniser; a bit changes once stages two and three agree.
// Assumes the input is a level that holds longer than three destination clocks.
`timescale 1ns/10ps
module tw_sync import tw_pkg::*; #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   assign q_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
   assign q      = q_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg  <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= q_next;
      end
   end
endmodule

// ===== tw_link.sv
// Link engine on the host's clock: frames instructions, hands them to the core, answers.
// Assumes the host samples the data line on the falling link clock edge.
`timescale 1ns/10ps
module tw_link import tw_pkg::*; (
   input  wire logic  debug_link_clock,
   input  wire logic  rst,
   tw_xfer_if.link    x,
   input  wire logic  data_in,
   output logic       data_out,
   output logic       data_oe
);
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_INS  = 3'b001,
      L_WDAT = 3'b010,
      L_WAIT = 3'b011,
      L_RDAT = 3'b100
   } tw_lstate_e;

   tw_lstate_e state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] sh_reg, sh_next;
   tw_instr_e  instr_reg, instr_next;
   logic       req_reg, req_next;
   logic       seen_reg, seen_next;
   logic       dout_reg, dout_next;
   logic       oe_reg, oe_next;
   logic [1:0] xs;
   logic       ack_s;
   logic       halt_s;

   tw_sync #(.W(2)) u_sync (
      .clk (debug_link_clock),
      .rst (rst),
      .d   ({x.ack_tog, x.halted}),
      .q   (xs)
   );
   assign ack_s     = xs[1];
   assign halt_s    = xs[0];
   assign x.req_tog = req_reg;
   assign x.instr   = instr_reg;
   assign x.wdata   = sh_reg;
   assign data_out  = dout_reg;
   assign data_oe   = oe_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 3'h1;
      sh_next    = {data_in, sh_reg[7:1]};
      instr_next = instr_reg;
      req_next   = req_reg;
      seen_next  = seen_reg;
      dout_next  = 1'b0;
      oe_next    = 1'b0;
      case (state_reg)
         L_IDLE: begin
            cnt_next = '0;
            // Our own drive stands on the pin for one edge after a frame; no false start
            if (!data_in && !oe_reg) state_next = L_INS; // [RL11]
         end
         L_INS: if (cnt_reg == TW_INS_LAST) begin
            instr_next = tw_instr_e'({data_in, sh_reg[7]});
            cnt_next   = '0;
            // Writes request only once their data byte is in
            if (sh_reg[7]) state_next = L_WDAT;
            else begin
               state_next = L_WAIT;
               req_next   = ~req_reg;
               oe_next    = 1'b1;
            end
         end
         L_WDAT: if (cnt_reg == TW_BYTE_LAST) begin
            state_next = L_WAIT;
            req_next   = ~req_reg;
            oe_next    = 1'b1;
         end
         L_WAIT: begin
            sh_next = sh_reg;
            oe_next = 1'b1;
            cnt_next = '0;
            if (ack_s != seen_reg) begin // [RL11]
               seen_next  = ack_s;
               dout_next  = 1'b1;
               sh_next    = x.rdata;
               state_next = instr_reg[0] ? L_IDLE : L_RDAT;
            end
         end
         L_RDAT: begin
            sh_next   = {1'b0, sh_reg[7:1]};
            dout_next = sh_reg[0];
            oe_next   = 1'b1;
            if (cnt_reg == TW_BYTE_LAST) state_next = L_IDLE;
         end
         default: state_next = L_IDLE;
      endcase
      if (!halt_s) begin // [RL7]
         state_next = L_IDLE;
         oe_next    = 1'b0;
      end
   end

   always_ff @(posedge debug_link_clock or posedge rst) begin
      if (rst) begin
         state_reg <= L_IDLE;
         cnt_reg   <= '0;
         sh_reg    <= '0;
         instr_reg <= TW_I_DRD;
         req_reg   <= 1'b0;
         seen_reg  <= 1'b0;
         dout_reg  <= 1'b0;
         oe_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         instr_reg <= instr_next;
         req_reg   <= req_next;
         seen_reg  <= seen_next;
         dout_reg  <= dout_next;
         oe_reg    <= oe_next;
      end
   end
endmodule

// ===== tw_flash_prog_regs.sv
// Core-clock register set of the two-wire debug and flash programming link.
// Assumes the core reports its halt state on mclk and the host clocks the link itself.
//
// Operation
// RL1: The revision register at link address 0x01 is read-only and returns an 8-bit code.
// RL2: The programming control register at 0x02 is 8 bits wide and resets to zero.
// RL3: Programming is granted only after the codes 0x02 then 0x01 are written to control.
// RL4: Once programming is granted the part stays out of normal running until reset.
// RL5: The programming data register at 0xAD, 8 bits, reset zero, carries command then bytes.
// RL6: Command bytes decode as 0x06 block read, 0x07 block write, 0x08 page erase, 0x03 erase all.
// RL7: Link transactions take effect only while the core and peripherals are halted.
// RL8: While halted the reset pin serves as link clock and a shared pin as link data.
// RL9: A user input sharing the data pin holds steady while the part is halted.
// RL10: The system drives the reset pin only as an input to the part.
// RL11: The link is one host-driven clock line and one two-way data line.
// RL12: An 8-bit select register steers data reads and writes to 0x00, 0x01, 0x02 or 0xAD.
// RL13: The part identifier at 0x00 is read-only and returns a fixed 8-bit family code.
// RL14: A control write out of order keeps programming off and restarts the code sequence.
// RL15: Command bytes outside the four codes are ignored and change no flash state.
`timescale 1ns/10ps
module tw_flash_prog_regs import tw_pkg::*; #(
   parameter logic [7:0] PART_ID = 8'h5a,
   parameter logic [7:0] REV_ID  = 8'h3c
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        debug_link_clock,
   input  wire logic        debug_link_data_in,
   output logic             debug_link_data_out,
   output logic             debug_link_data_oe,
   input  wire logic        core_halted,
   input  wire logic [7:0]  flash_rdata,
   input  wire logic        flash_rdata_valid,
   input  wire logic        flash_done,
   output logic             link_owns_pins,
   output logic             prog_mode,
   output tw_fcmd_e         flash_cmd,
   output logic             flash_cmd_valid,
   output logic [7:0]       flash_arg,
   output logic             flash_arg_valid,
   output logic             flash_read_req
);
   typedef enum logic [1:0] {
      EN_IDLE = 2'b00,
      EN_HALF = 2'b01,
      EN_ON   = 2'b10
   } tw_en_e;

   tw_xfer_if x ();

   tw_en_e     en_reg, en_next;
   logic [7:0] sel_reg, sel_next;
   logic [7:0] ctl_reg, ctl_next;
   logic [7:0] dat_reg, dat_next;
   logic [7:0] rdata_reg;
   logic       ack_reg;
   logic       seen_reg;
   logic       halted_reg;
   logic       arg_phase_reg, arg_phase_next;
   logic       prog_reg;
   tw_fcmd_e   fcmd_reg;
   logic       fcmd_vld_reg;
   logic [7:0] farg_reg;
   logic       farg_vld_reg;
   logic       frd_reg;
   logic       req_s;
   logic       new_req;
   logic       live;
   logic       ctl_we;
   logic       dat_we;
   logic       sel_we;
   logic       dat_rd;
   logic       en_on;
   tw_fcmd_e   wr_cmd;
   logic       cmd_ok;
   logic       take_cmd;
   logic       take_arg;
   logic [7:0] rd_value;
   logic [7:0] rdata_next;

   // The reset pin carries the link clock; it must never be an output here [RL10]
   tw_link u_link (
      .debug_link_clock (debug_link_clock),
      .rst              (rst),
      .x                (x.link),
      .data_in          (debug_link_data_in),
      .data_out         (debug_link_data_out),
      .data_oe          (debug_link_data_oe)
   );

   tw_sync #(.W(1)) u_req_sync (
      .clk (mclk),
      .rst (rst),
      .d   (x.req_tog),
      .q   (req_s)
   );

   function automatic logic [7:0] reg_read(input logic [7:0] sel, input logic [7:0] ctl,
                                           input logic [7:0] dat);
      if (sel == TW_ADDR_PART) return PART_ID; // [RL13]
      else if (sel == TW_ADDR_REV) return REV_ID; // [RL1]
      else if (sel == TW_ADDR_CTL) return ctl;
      else if (sel == TW_ADDR_DAT) return dat;
      else return 8'h00;
   endfunction

   assign x.ack_tog = ack_reg;
   assign x.rdata   = rdata_reg;
   assign x.halted  = halted_reg;

   // Fields are stable by the time the toggle is through the synchroniser
   assign new_req  = req_s != seen_reg;
   assign live     = new_req && halted_reg; // [RL7]
   assign ctl_we   = live && x.instr == TW_I_DWR && sel_reg == TW_ADDR_CTL;
   assign dat_we   = live && x.instr == TW_I_DWR && sel_reg == TW_ADDR_DAT; // [RL5]
   assign dat_rd   = live && x.instr == TW_I_DRD && sel_reg == TW_ADDR_DAT;
   assign sel_we   = live && x.instr == TW_I_AWR; // [RL12]
   assign en_on    = en_reg == EN_ON;
   assign wr_cmd   = tw_cmd_decode(x.wdata); // [RL6]
   assign cmd_ok   = wr_cmd != TW_FC_NONE; // [RL15]
   assign take_cmd = dat_we && en_on && !arg_phase_reg && cmd_ok;
   assign take_arg = dat_we && en_on && arg_phase_reg;
   assign rd_value = reg_read(sel_reg, ctl_reg, dat_reg); // [RL12]

   assign sel_next = sel_we ? x.wdata : sel_reg;
   assign ctl_next = ctl_we ? x.wdata : ctl_reg; // [RL2]
   // A flash read result wins over a host write in the same cycle
   assign dat_next = flash_rdata_valid ? flash_rdata : (dat_we ? x.wdata : dat_reg);
   assign arg_phase_next = take_cmd ? 1'b1 : (flash_done ? 1'b0 : arg_phase_reg);

   always_comb begin
      rdata_next = 8'h00;
      if (!live) rdata_next = 8'h00;
      else if (x.instr == TW_I_ARD) rdata_next = sel_reg;
      else if (x.instr == TW_I_DRD) rdata_next = rd_value;
      else rdata_next = rdata_reg;
   end

   always_comb begin
      en_next = en_reg;
      case (en_reg)
         EN_IDLE: begin
            if (ctl_we && x.wdata == TW_EN_CODE1) en_next = EN_HALF; // [RL3]
         end
         EN_HALF: begin
            if (ctl_we && x.wdata == TW_EN_CODE2) en_next = EN_ON; // [RL3]
            else if (ctl_we && x.wdata != TW_EN_CODE1) en_next = EN_IDLE; // [RL14]
         end
         EN_ON: en_next = EN_ON; // [RL4]
         default: en_next = EN_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         en_reg        <= EN_IDLE;
         sel_reg       <= TW_SEL_RST;
         ctl_reg       <= TW_CTL_RST;
         dat_reg       <= TW_DAT_RST;
         arg_phase_reg <= 1'b0;
         prog_reg      <= 1'b0;
      end else begin
         en_reg        <= en_next;
         sel_reg       <= sel_next;
         ctl_reg       <= ctl_next;
         dat_reg       <= dat_next;
         arg_phase_reg <= arg_phase_next;
         prog_reg      <= en_next == EN_ON; // [RL4]
      end
   end

   // Every request is answered, even when dropped, so the link never hangs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seen_reg   <= 1'b0;
         ack_reg    <= 1'b0;
         rdata_reg  <= 8'h00;
         halted_reg <= 1'b0;
      end else begin
         seen_reg   <= req_s;
         ack_reg    <= new_req ? ~ack_reg : ack_reg; // [RL11]
         rdata_reg  <= new_req ? rdata_next : rdata_reg;
         halted_reg <= core_halted; // [RL8]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fcmd_reg     <= TW_FC_NONE;
         fcmd_vld_reg <= 1'b0;
         farg_reg     <= 8'h00;
         farg_vld_reg <= 1'b0;
         frd_reg      <= 1'b0;
      end else begin
         fcmd_reg     <= take_cmd ? wr_cmd : fcmd_reg; // [RL6]
         fcmd_vld_reg <= take_cmd;
         farg_reg     <= take_arg ? x.wdata : farg_reg; // [RL5]
         farg_vld_reg <= take_arg;
         frd_reg      <= dat_rd && en_on;
      end
   end

   assign link_owns_pins  = halted_reg; // [RL8]
   assign prog_mode       = prog_reg;
   assign flash_cmd       = fcmd_reg;
   assign flash_cmd_valid = fcmd_vld_reg;
   assign flash_arg       = farg_reg;
   assign flash_arg_valid = farg_vld_reg;
   assign flash_read_req  = frd_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_REV_READ: assert property ( // [RL1]
      live && x.instr == TW_I_DRD && sel_reg == TW_ADDR_REV |=> rdata_reg == REV_ID)
      else $error("revision read returned wrong code");
   AST_PART_READ: assert property ( // [RL13]
      live && x.instr == TW_I_DRD && sel_reg == TW_ADDR_PART |=> rdata_reg == PART_ID)
      else $error("part identifier read returned wrong code");
   AST_CTL_WRITE: assert property ( // [RL2]
      ctl_we |=> ctl_reg == $past(x.wdata))
      else $error("control write not stored");
   AST_EN_GRANT: assert property ( // [RL3]
      en_reg == EN_HALF && ctl_we && x.wdata == TW_EN_CODE2 |=> prog_mode ##1 prog_mode)
      else $error("ordered codes did not grant programming");
   AST_EN_BREAK: assert property ( // [RL14]
      !prog_mode && !(en_reg == EN_HALF && ctl_we && x.wdata == TW_EN_CODE2) |=> !prog_mode)
      else $error("programming granted without ordered codes");
   AST_PROG_STAYS: assert property ( // [RL4]
      prog_mode |=> prog_mode)
      else $error("programming mode left without reset");
   AST_DAT_WRITE: assert property ( // [RL5]
      dat_we && !flash_rdata_valid |=> dat_reg == $past(x.wdata))
      else $error("data register write not stored");
   AST_CMD_ERASE: assert property ( // [RL6]
      dat_we && en_on && !arg_phase_reg && x.wdata == TW_CMD_PG_ER
      |=> flash_cmd_valid && flash_cmd == TW_FC_PG_ER ##1 !flash_cmd_valid)
      else $error("page erase command not decoded");
   AST_CMD_UNKNOWN: assert property ( // [RL15]
      dat_we && !arg_phase_reg && !cmd_ok |=> !flash_cmd_valid && !arg_phase_reg)
      else $error("unknown command was acted on");
   AST_NOT_HALTED: assert property ( // [RL7]
      !halted_reg |=> $stable(ctl_reg) && $stable(sel_reg) && $stable(en_reg))
      else $error("register changed while not halted");
   AST_SEL_WRITE: assert property ( // [RL12]
      sel_we |=> sel_reg == $past(x.wdata))
      else $error("select write not stored");
   AST_ANSWER: assert property ( // [RL11]
      new_req |=> ack_reg != $past(ack_reg) ##1 !new_req)
      else $error("request not answered once");

   COV_GRANT: cover property ($rose(prog_mode));
   COV_CMD: cover property (flash_cmd_valid ##[1:200] flash_arg_valid);
   COV_READ: cover property (flash_read_req);
endmodule

// ===== tw_host.sv
// Host model: drives the link clock and the host side of the two-way data pin.
// Assumes the bench resolves the pin level from both drivers and feeds it back.
`timescale 1ns/10ps
module tw_host import tw_pkg::*; (
   output logic      link_clk,
   output logic      drv,
   output logic      drv_oe,
   input  wire logic line
);
   initial begin
      link_clk = 1'b0; // Clock stands still between frames
      drv = 1'b1;
      drv_oe = 1'b0;
   end
   // Only this model moves the shared reset pin; the device just listens
   task automatic tick();
      #15 link_clk = 1'b1;
      #15 link_clk = 1'b0;
   endtask
   // Idle ones first so the halt level can cross into the link domain
   task automatic frame(input tw_instr_e ins, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ok);
      logic [1:0] ib;
      int         n;
      ib = ins;
      rd = 8'h00;
      ok = 1'b0;
      n = 0;
      drv_oe = 1'b1;
      drv = 1'b1;
      repeat (6) tick();
      drv = 1'b0;
      tick();
      for (int i = 0; i < 2; i++) begin
         drv = ib[i];
         tick();
      end
      if (ib[0]) begin
         for (int i = 0; i < 8; i++) begin
            drv = wd[i];
            tick();
         end
      end
      drv_oe = 1'b0;
      // Bounded wait so a silent device cannot hang the host
      while (ok !== 1'b1 && n < 100) begin
         tick();
         n++;
         if (line === 1'b1) ok = 1'b1;
      end
      if (ok === 1'b1 && !ib[0]) begin
         for (int i = 0; i < 8; i++) begin
            tick();
            rd[i] = line;
         end
      end
      tick();
   endtask
endmodule

// ===== two_wire_flash_prog_regs_tb.sv
// Self-checking bench for the two-wire flash programming registers, with a host model.
// Assumes the handover timing of the link frames and of the core strobes.
`timescale 1ns/10ps
module two_wire_flash_prog_regs_tb import tw_pkg::*;;
   localparam logic [7:0] PID = 8'h4b; // Arbitrary value
   localparam logic [7:0] RID = 8'h2d; // Arbitrary value
   logic       mclk, rst, core_halted, flash_rdata_valid, flash_done, pat, ok;
   logic [7:0] flash_rdata, rd, v;
   wire logic  link_clk, h_drv, h_oe, d_out, d_oe, line;
   logic       link_owns_pins, prog_mode, flash_cmd_valid, flash_arg_valid, flash_read_req;
   tw_fcmd_e   flash_cmd;
   logic [7:0] flash_arg;
   int         errors, compares, seed, m_sel, m_ctl, m_dat, m_stg, m_prog, m_ph, exp_rq, got_rq;
   logic [7:0] exp_cmd[$], exp_arg[$], got_cmd[$], got_arg[$];
   logic [7:0] addrs[6] = '{8'h00, 8'h01, 8'h02, 8'had, 8'h55, 8'h01};
   logic [7:0] ctl_seq[7] = '{8'h01, 8'h02, 8'h05, 8'h01, 8'h02, 8'h02, 8'h01};
   logic [7:0] cmds[4] = '{8'h06, 8'h07, 8'h08, 8'h03};

   // A released pin toggles while running, but the user side holds still when halted
   assign line = d_oe ? d_out : (h_oe ? h_drv : pat);
   always #50 mclk = ~mclk;
   always @(posedge mclk) if (!core_halted) pat <= ~pat;
   // Sampled on the falling edge, clear of the design's own updates
   always @(negedge mclk) begin
      if (flash_cmd_valid === 1'b1) got_cmd.push_back({5'h00, flash_cmd});
      if (flash_arg_valid === 1'b1) got_arg.push_back(flash_arg);
      if (flash_read_req === 1'b1) got_rq++;
   end

   tw_host host (.link_clk(link_clk), .drv(h_drv), .drv_oe(h_oe), .line(line));
   tw_flash_prog_regs #(.PART_ID(PID), .REV_ID(RID)) uut (
      .mclk(mclk), .rst(rst), .debug_link_clock(link_clk), .debug_link_data_in(line),
      .debug_link_data_out(d_out), .debug_link_data_oe(d_oe), .core_halted(core_halted),
      .flash_rdata(flash_rdata), .flash_rdata_valid(flash_rdata_valid),
      .flash_done(flash_done), .link_owns_pins(link_owns_pins), .prog_mode(prog_mode),
      .flash_cmd(flash_cmd), .flash_cmd_valid(flash_cmd_valid), .flash_arg(flash_arg),
      .flash_arg_valid(flash_arg_valid), .flash_read_req(flash_read_req));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string what);
      chk({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic close_out();
      $display("Counts: %0d compares, %0d errors", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] code_of(input logic [7:0] c);
      case (c)
         8'h06: return 8'h01;
         8'h07: return 8'h02;
         8'h08: return 8'h03;
         8'h03: return 8'h04;
         default: return 8'h00;
      endcase
   endfunction
   task automatic xfer(input tw_instr_e ins, input logic [7:0] wd, output logic [7:0] r);
      logic k;
      host.frame(ins, wd, r, k);
      chk_flag(k, 1'b1, "link ready");
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer(TW_I_AWR, a, r);
      m_sel = a;
      xfer(TW_I_DWR, d, r);
      if (a == TW_ADDR_CTL) begin
         m_ctl = d;
         if (m_prog == 0) m_stg = (d == TW_EN_CODE1) ? 1 : ((d == TW_EN_CODE2 && m_stg == 1) ? 2 : 0);
         if (m_stg == 2) m_prog = 1;
      end
      if (a == TW_ADDR_DAT) begin
         m_dat = d;
         if (m_prog == 1 && m_ph == 1) exp_arg.push_back(d);
         if (m_prog == 1 && m_ph == 0 && code_of(d) != 8'h00) begin
            exp_cmd.push_back(code_of(d));
            m_ph = 1;
         end
      end
      repeat (4) @(posedge mclk);
      chk_flag(prog_mode, m_prog[0], "prog mode");
   endtask
   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] r, e;
      e = (a == TW_ADDR_PART) ? PID : (a == TW_ADDR_REV) ? RID : 8'h00;
      if (a == TW_ADDR_CTL) e = m_ctl[7:0];
      if (a == TW_ADDR_DAT) e = m_dat[7:0];
      xfer(TW_I_AWR, a, r);
      m_sel = a;
      xfer(TW_I_DRD, 8'h00, r);
      if (a == TW_ADDR_DAT && m_prog == 1) exp_rq++;
      chk(r, e, "register read");
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (6) @(posedge mclk);
      chk_flag(prog_mode, 1'b0, "prog in reset");
      rst <= 1'b0;
      {m_sel, m_ctl, m_dat, m_stg, m_prog, m_ph} = '0;
      repeat (8) @(posedge mclk);
   endtask
   task automatic set_halt(input logic h);
      core_halted <= h;
      repeat (8) @(posedge mclk);
      chk_flag(link_owns_pins, h, "pins borrowed");
   endtask

   initial begin
      #2000000;
      errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      {mclk, rst, core_halted, flash_rdata_valid, flash_done, pat} = 6'b010000;
      flash_rdata = 8'h00;
      {errors, compares, exp_rq, got_rq} = '0;
      seed = 32'h9553;
      do_reset();
      set_halt(1'b1);
      foreach (addrs[i]) begin
         if (i == 5) reg_wr(TW_ADDR_REV, 8'hff);
         rd_chk(addrs[i]);
         xfer(TW_I_ARD, 8'h00, rd);
         chk(rd, addrs[i], "select readback");
      end
      v = 8'($random(seed)) | 8'h80;
      reg_wr(TW_ADDR_CTL, v);
      rd_chk(TW_ADDR_CTL);
      reg_wr(TW_ADDR_DAT, 8'h07);
      set_halt(1'b0);
      host.frame(TW_I_AWR, TW_ADDR_CTL, rd, ok);
      host.frame(TW_I_DWR, TW_EN_CODE1, rd, ok);
      set_halt(1'b1);
      rd_chk(TW_ADDR_CTL);
      foreach (ctl_seq[i]) reg_wr(TW_ADDR_CTL, ctl_seq[i]);
      reg_wr(TW_ADDR_DAT, 8'h55);
      foreach (cmds[i]) begin
         reg_wr(TW_ADDR_DAT, cmds[i]);
         reg_wr(TW_ADDR_DAT, 8'($random(seed)));
         flash_rdata <= 8'($random(seed));
         flash_rdata_valid <= 1'b1;
         @(posedge mclk);
         flash_rdata_valid <= 1'b0;
         m_dat = flash_rdata;
         rd_chk(TW_ADDR_DAT);
         flash_done <= 1'b1;
         @(posedge mclk);
         flash_done <= 1'b0;
         m_ph = 0;
      end
      reg_wr(TW_ADDR_CTL, 8'h00);
      set_halt(1'b0);
      chk_flag(prog_mode, 1'b1, "prog held");
      set_halt(1'b1);
      chk(8'(got_cmd.size()), 8'(exp_cmd.size()), "command count");
      foreach (exp_cmd[i]) chk(got_cmd[i], exp_cmd[i], "flash command");
      chk(8'(got_arg.size()), 8'(exp_arg.size()), "byte count");
      foreach (exp_arg[i]) chk(got_arg[i], exp_arg[i], "flash byte");
      chk(8'(got_rq), 8'(exp_rq), "read requests");
      do_reset();
      chk_flag(prog_mode, 1'b0, "prog after reset");
      rd_chk(TW_ADDR_CTL);
      rd_chk(TW_ADDR_DAT);
      close_out();
   end
endmodule
